// ==== hdl/ccr_regs.sv ====
`timescale 1ns/1ps
`default_nettype none
module ccr_regs (
   input wire logic clk,
   input wire logic nrst,
   input wire logic [7:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic [2:0] strap_select_pins,
   input wire logic mode_sync_pin,
   output logic [7:0] reg_rdata,
   output logic reg_ready,
   output logic soft_reset_pulse,
   output logic spread_spectrum_enable,
   output logic software_switch_enable,
   output logic forced_fixed_freq_enable,
   output logic output_discharge_enable,
   output logic hiccup_mode_enable,
   output logic [1:0] voltage_ramp_speed,
   output logic [1:0] setpoint_range_select,
   output logic [1:0] soft_start_duration,
   output logic single_operation,
   output logic power_good_blank_on_scaling
);
   // ==========================================
   // field map
   // control one, offset 01:
   //   bit 7 soft reset; write one to restart, always reads zero
   //   bit 6 spread spectrum clocking enable, clear after reset
   //   bit 5 switching enable, set after reset
   //     clearing it stops switching but keeps every register
   //     setting it starts switching without the enable delay
   //   bit 4 forced fixed frequency, ored with the synced mode pin
   //     a high pin or a sync clock wins over a clear bit
   //   bit 3 active output discharge, set after reset
   //   bit 2 hiccup enable, clear after reset
   //     stacking restriction is left to software
   //   bits 1-0 ramp speed between setpoints, 10 after reset
   //     00 fastest, 11 slowest; the core owns the actual slope
   // control two, offset 02:
   //   bits 7-4 reserved, masked on write, read zero
   //   bits 3-2 setpoint range
   //     reset value comes from the straps, not a constant
   //     00 finest steps, 11 coarsest steps and highest floor
   //   bits 1-0 soft-start time, 01 after reset
   //     each step up doubles the ramp time
   // control three, offset 03:
   //   bits 7-2 reserved, masked on write, read zero
   //   bit 1 single operation, clear after reset
   //     set drops the enable pulldown and the sync output
   //   bit 0 power good blanking while the setpoint moves
   //     clear lets the window comparator drive power good
   // any other offset reads zero and ignores writes
   //
   // timing:
   //   a write strobe lands in its register on its own edge
   //   and reaches the outputs one edge later
   //   read data follows the address by one edge
   //   power-up and soft reset both start the lockout
   //   the straps are caught on the last lockout cycle,
   //   long after the synchroniser has settled
   //   writes inside the lockout are dropped, not queued;
   //   queueing would need a buffer the engine does not expect
   //   the mode pin path is three edges: two sync flops
   //   and the output flop
   //
   // hazards:
   //   a soft reset write resets control one on the same edge,
   //   so the other bits of that byte are lost on purpose
   //   reg_ready is registered and trails the lockout by one edge;
   //   a write on the edge right after a soft reset is still dropped
   //   software that needs a known range must write it after
   //   the lockout, since the straps decide it before then
   //   strap bit 2 is synchronised but unused here; it only
   //   picks the interface address, which lives outside this block
   //   outputs read zero while nrst is low; the core must not
   //   act on them until reset has been released
   //
   // outputs:
   //   every output comes straight from a flop, one per field,
   //   so the core never sees a decode glitch
   // ==========================================
   // pin synchronisers
   logic [2:0] strap_s;
   logic mode_s;
   ccr_sync #(.W(3)) u_strap (
      .clk(clk),
      .nrst(nrst),
      .async_in(strap_select_pins),
      .sync_out(strap_s)
   );
   ccr_sync #(.W(1)) u_mode (
      .clk(clk),
      .nrst(nrst),
      .async_in(mode_sync_pin),
      .sync_out(mode_s)
   );

   // ==========================================
   // storage
   logic [6:0] ctl1;
   logic [3:0] ctl2;
   logic [1:0] ctl3;
   logic strap_taken;
   logic [ccr_pkg::DELAY_W-1:0] busy_cnt;

   // ==========================================
   // decode; writes land on the strobe marking acknowledge fall
   wire hit1 = reg_addr == ccr_pkg::ADDR_CONTROL_ONE;
   wire hit2 = reg_addr == ccr_pkg::ADDR_CONTROL_TWO;
   wire hit3 = reg_addr == ccr_pkg::ADDR_CONTROL_THREE;
   wire busy = busy_cnt != '0;
   wire wr_ok = reg_wr && !busy;
   wire soft_rst = wr_ok && hit1 && reg_wdata[ccr_pkg::SOFT_RESET_BIT];
   wire [7:0] rd1 = {1'b0, ctl1};
   wire [7:0] rd2 = {4'h0, ctl2};
   wire [7:0] rd3 = {6'h00, ctl3};
   // read select; unmapped offsets give zero so a stray read sees nothing
   logic [7:0] next_rdata;
   always_comb begin
      if (hit1) begin
         next_rdata = rd1;
      end else if (hit2) begin
         next_rdata = rd2;
      end else if (hit3) begin
         next_rdata = rd3;
      end else begin
         next_rdata = 8'h00;
      end
   end
   // range from straps: low two synchronised strap bits pick the range
   wire [1:0] strap_range = strap_s[1:0];

   // ==========================================
   // control one
   always_ff @(posedge clk) begin
      if (!nrst || soft_rst) begin
         ctl1 <= ccr_pkg::CONTROL_ONE_RESET[6:0];
      end else if (wr_ok && hit1) begin
         ctl1 <= reg_wdata[6:0] & ccr_pkg::CONTROL_ONE_MASK[6:0];
      end
   end

   // control two; range caught after reset release since the straps need
   // two clocks through the synchroniser before they are valid
   always_ff @(posedge clk) begin
      if (!nrst || soft_rst) begin
         ctl2 <= {2'h0, ccr_pkg::SOFT_START_DURATION_RESET};
         strap_taken <= 1'b0;
      end else if (!strap_taken) begin
         if (busy_cnt == ccr_pkg::DELAY_W'(1)) begin
            ctl2[3:2] <= strap_range;
            strap_taken <= 1'b1;
         end
      end else if (wr_ok && hit2) begin
         ctl2 <= reg_wdata[3:0] & ccr_pkg::CONTROL_TWO_MASK[3:0];
      end
   end

   // control three
   always_ff @(posedge clk) begin
      if (!nrst || soft_rst) begin
         ctl3 <= ccr_pkg::CONTROL_THREE_RESET[1:0];
      end else if (wr_ok && hit3) begin
         ctl3 <= reg_wdata[1:0] & ccr_pkg::CONTROL_THREE_MASK[1:0];
      end
   end

   // start-up lockout; registers frozen until the delay runs out
   always_ff @(posedge clk) begin
      if (!nrst || soft_rst) begin
         busy_cnt <= ccr_pkg::DELAY_W'(ccr_pkg::ENABLE_DELAY2_CYCLES);
      end else if (busy) begin
         busy_cnt <= busy_cnt - ccr_pkg::DELAY_W'(1);
      end
   end

   // ==========================================
   // next values for the registered outputs; each field but the soft reset pulse feeds the core
   // as a static level, so it moves only on a write, a reset, the strap capture or the pin
   wire next_ready = !busy;
   wire next_pulse = soft_rst;
   wire next_spread = ctl1[ccr_pkg::SSC_BIT];
   wire next_switch = ctl1[ccr_pkg::SOFTWARE_SWITCH_ENABLE_BIT];
   wire next_fixed_freq = ctl1[ccr_pkg::FPWM_BIT] | mode_s;
   wire next_discharge = ctl1[ccr_pkg::DISCH_BIT];
   wire next_hiccup = ctl1[ccr_pkg::HICCUP_BIT];
   wire [1:0] next_ramp = ctl1[ccr_pkg::RAMP_LSB +: 2];
   wire [1:0] next_range = ctl2[ccr_pkg::RANGE_LSB +: 2];
   wire [1:0] next_soft_start = ctl2[ccr_pkg::SOFT_START_DURATION_LSB +: 2];
   wire next_single = ctl3[ccr_pkg::SINGLE_BIT];
   wire next_pg_blank = ctl3[ccr_pkg::PGBLANK_BIT];

   // read data, one edge behind the address
   always_ff @(posedge clk) begin
      if (!nrst) begin
         reg_rdata <= 8'h00;
      end else begin
         reg_rdata <= next_rdata;
      end
   end

   // write ready; trails the lockout by one edge
   always_ff @(posedge clk) begin
      if (!nrst) begin
         reg_ready <= 1'b0;
      end else begin
         reg_ready <= next_ready;
      end
   end

   // soft reset restart request, one cycle wide
   always_ff @(posedge clk) begin
      if (!nrst) begin
         soft_reset_pulse <= 1'b0;
      end else begin
         soft_reset_pulse <= next_pulse;
      end
   end

   // spread spectrum level
   always_ff @(posedge clk) begin
      if (!nrst) begin
         spread_spectrum_enable <= 1'b0;
      end else begin
         spread_spectrum_enable <= next_spread;
      end
   end

   // switching enable level
   always_ff @(posedge clk) begin
      if (!nrst) begin
         software_switch_enable <= 1'b0;
      end else begin
         software_switch_enable <= next_switch;
      end
   end

   // forced fixed frequency; the pin can only force it on
   always_ff @(posedge clk) begin
      if (!nrst) begin
         forced_fixed_freq_enable <= 1'b0;
      end else begin
         forced_fixed_freq_enable <= next_fixed_freq;
      end
   end

   // output discharge level
   always_ff @(posedge clk) begin
      if (!nrst) begin
         output_discharge_enable <= 1'b0;
      end else begin
         output_discharge_enable <= next_discharge;
      end
   end

   // hiccup level
   always_ff @(posedge clk) begin
      if (!nrst) begin
         hiccup_mode_enable <= 1'b0;
      end else begin
         hiccup_mode_enable <= next_hiccup;
      end
   end

   // ramp speed code
   always_ff @(posedge clk) begin
      if (!nrst) begin
         voltage_ramp_speed <= 2'h0;
      end else begin
         voltage_ramp_speed <= next_ramp;
      end
   end

   // setpoint range code
   always_ff @(posedge clk) begin
      if (!nrst) begin
         setpoint_range_select <= 2'h0;
      end else begin
         setpoint_range_select <= next_range;
      end
   end

   // soft-start time code
   always_ff @(posedge clk) begin
      if (!nrst) begin
         soft_start_duration <= 2'h0;
      end else begin
         soft_start_duration <= next_soft_start;
      end
   end

   // single operation level
   always_ff @(posedge clk) begin
      if (!nrst) begin
         single_operation <= 1'b0;
      end else begin
         single_operation <= next_single;
      end
   end

   // power good blanking level
   always_ff @(posedge clk) begin
      if (!nrst) begin
         power_good_blank_on_scaling <= 1'b0;
      end else begin
         power_good_blank_on_scaling <= next_pg_blank;
      end
   end
endmodule : ccr_regs
`default_nettype wire

// ==== hdl/ccr_pkg.sv ====
`default_nettype none
package ccr_pkg;
   // ==========================================
   // register offsets
   localparam logic [7:0] ADDR_CONTROL_ONE = 8'h01;
   localparam logic [7:0] ADDR_CONTROL_TWO = 8'h02;
   localparam logic [7:0] ADDR_CONTROL_THREE = 8'h03;
   // ==========================================
   // field positions
   localparam int SOFT_RESET_BIT = 7;
   localparam int SSC_BIT = 6;
   localparam int SOFTWARE_SWITCH_ENABLE_BIT = 5;
   localparam int FPWM_BIT = 4;
   localparam int DISCH_BIT = 3;
   localparam int HICCUP_BIT = 2;
   localparam int RAMP_LSB = 0;
   localparam int RANGE_LSB = 2;
   localparam int SOFT_START_DURATION_LSB = 0;
   localparam int SINGLE_BIT = 1;
   localparam int PGBLANK_BIT = 0;
   // ==========================================
   // reset values and writable masks
   localparam logic [7:0] CONTROL_ONE_RESET = 8'h2a;
   localparam logic [1:0] SOFT_START_DURATION_RESET = 2'h1;
   localparam logic [7:0] CONTROL_THREE_RESET = 8'h00;
   localparam logic [7:0] CONTROL_ONE_MASK = 8'h7f;
   localparam logic [7:0] CONTROL_TWO_MASK = 8'h0f;
   localparam logic [7:0] CONTROL_THREE_MASK = 8'h03;
   // ==========================================
   // timing: second enable delay before registers reopen
   localparam int CLK_MHZ = 100;
   localparam int ENABLE_DELAY2_US = 20;
   localparam int ENABLE_DELAY2_CYCLES = ENABLE_DELAY2_US * CLK_MHZ;
   localparam int DELAY_W = 16;
endpackage : ccr_pkg
`default_nettype wire

// ==== hdl/ccr_sync.sv ====
`timescale 1ns/1ps
`default_nettype none
module ccr_sync #(
   parameter int W = 1
) (
   input wire logic clk,
   input wire logic nrst,
   input wire logic [W-1:0] async_in,
   output logic [W-1:0] sync_out
);
   logic [W-1:0] stage1;
   // two flops; first stage read only by second
   always_ff @(posedge clk) begin
      if (!nrst) begin
         stage1 <= '0;
         sync_out <= '0;
      end else begin
         stage1 <= async_in;
         sync_out <= stage1;
      end
   end
endmodule : ccr_sync
`default_nettype wire

// ==== tb/ccr_regs_sva.sv ====
`timescale 1ns/1ps
`default_nettype none
// ==========
// port checker
module ccr_regs_sva (
   input wire logic clk,
   input wire logic nrst,
   input wire logic [7:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic [7:0] reg_rdata,
   input wire logic reg_ready,
   input wire logic soft_reset_pulse,
   input wire logic software_switch_enable,
   input wire logic [1:0] voltage_ramp_speed,
   input wire logic [1:0] soft_start_duration
);
   default clocking @(posedge clk); endclocking
   default disable iff (!nrst);
   // read path: hidden, reserved and unmapped bits stay zero
   rst_bit_a: assert property (reg_addr == 8'h01 |=> !reg_rdata[7]) else $error("reset bit read");
   unmapped_a: assert property (reg_addr > 8'h03 |=> reg_rdata == 8'h00) else $error("unmapped read");
   rsvd_two_a: assert property (reg_addr == 8'h02 |=> reg_rdata[7:4] == 4'h0) else $error("rsvd two");
   rsvd_three_a: assert property (reg_addr == 8'h03 |=> reg_rdata[7:2] == 6'h00) else $error("rsvd 3");
   // soft reset: one pulse, lockout, defaults back on the outputs
   pulse_once_a: assert property (soft_reset_pulse |=> !soft_reset_pulse && !reg_ready)
      else $error("soft reset pulse");
   reset_dflt_a: assert property (soft_reset_pulse |=> software_switch_enable
      && voltage_ramp_speed == 2'h2) else $error("soft reset defaults");
   // writes land two edges on; a write just after a soft reset is dropped
   write_two_a: assert property (reg_wr && reg_ready && !soft_reset_pulse
      && reg_addr == 8'h02 |-> ##2 soft_start_duration == $past(reg_wdata[1:0], 2)) else $error("write lost");
   static_out_a: assert property ($changed(soft_start_duration) && $past(nrst) && $past(nrst, 2) |->
      $past(reg_wr, 2) || $past(soft_reset_pulse) || soft_reset_pulse) else $error("field moved");
   cover property (soft_reset_pulse);
   cover property (reg_wr && reg_ready && reg_addr == 8'h02);
   cover property (reg_addr > 8'h03);
endmodule : ccr_regs_sva
bind ccr_regs ccr_regs_sva chk (.*);
`default_nettype wire

// ==== tb/ccr_host.sv ====
`timescale 1ns/1ps
`default_nettype none
// ==========
// bus controller model, standalone device so hiccup and single may be set
module ccr_host (
   input wire logic clk,
   input wire logic [7:0] reg_rdata,
   output logic [7:0] reg_addr,
   output logic [7:0] reg_wdata,
   output logic reg_wr
);
   initial reg_addr = 8'h00;
   initial reg_wdata = 8'h00;
   initial reg_wr = 1'b0;
   // one byte, strobe at acknowledge fall; data scrambled once released
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(negedge clk);
      reg_addr = a;
      reg_wdata = d;
      reg_wr = 1'b1;
      @(negedge clk);
      reg_wr = 1'b0;
      reg_wdata = ~d;
   endtask : wr
   // read data is registered one edge after the address
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(negedge clk);
      reg_addr = a;
      @(negedge clk);
      d = reg_rdata;
   endtask : rd
endmodule : ccr_host
`default_nettype wire

// ==== tb/converter_control_registers_tb.sv ====
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin check_count++; if ((g) !== (e)) begin fail_count++; $display("[FAIL] %s exp %h got %h", n, e, g); end end
// ==========
// bench top
module converter_control_registers_tb;
   logic clk = 1'b0;
   logic nrst = 1'b0;
   logic [2:0] strap_select_pins = 3'h6;
   logic mode_sync_pin = 1'b0;
   logic [7:0] reg_addr, reg_wdata, reg_rdata, d;
   logic reg_wr, reg_ready, soft_reset_pulse, spread_spectrum_enable, software_switch_enable;
   logic forced_fixed_freq_enable, output_discharge_enable, hiccup_mode_enable, single_operation;
   logic power_good_blank_on_scaling;
   logic [1:0] voltage_ramp_speed, setpoint_range_select, soft_start_duration;
   logic [6:0] o1;
   logic [5:0] o23;
   logic [7:0] ra [4] = '{8'h01, 8'h02, 8'h03, 8'h40};
   logic [7:0] rv [4] = '{8'h2a, 8'h09, 8'h00, 8'h00};
   logic [7:0] wv [3] = '{8'h55, 8'hfe, 8'hff};
   logic [7:0] rb [3] = '{8'h55, 8'h0e, 8'h03};
   int fail_count = 0;
   int check_count = 0;
   ccr_regs uut (.*);
   ccr_host host (.*);
   initial begin
      forever #5 clk = ~clk;
   end
   task automatic end_of_test();
      $display("checks %0d mismatches %0d", check_count, fail_count);
      if (fail_count == 0 && check_count > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask : end_of_test
   // lockout ends within 3000 cycles
   task automatic wait_ready();
      for (int i = 0; i < 3000 && reg_ready !== 1'b1; i++) @(negedge clk);
      `CHK("ready", 1'b1, reg_ready)
   endtask : wait_ready
   // reset, writes with reserved bits set, mode pin, soft reset with a dropped write
   initial begin
      repeat (12) @(negedge clk);
      nrst = 1'b1;
      wait_ready();
      foreach (ra[i]) begin host.rd(ra[i], d); `CHK("reset", rv[i], d) end
      $display("test reset done");
      foreach (wv[i]) host.wr(ra[i], wv[i]);
      repeat (2) @(negedge clk);
      o1 = {spread_spectrum_enable, software_switch_enable, forced_fixed_freq_enable, output_discharge_enable,
            hiccup_mode_enable, voltage_ramp_speed};
      o23 = {setpoint_range_select, soft_start_duration, single_operation, power_good_blank_on_scaling};
      `CHK("ctl1", 7'h55, o1)
      `CHK("ctl23", 6'h3b, o23)
      foreach (wv[i]) begin host.rd(ra[i], d); `CHK("readback", rb[i], d) end
      $display("test write done");
      host.wr(8'h01, 8'h20);
      mode_sync_pin = 1'b1;
      repeat (5) @(negedge clk);
      `CHK("pin pwm", 1'b1, forced_fixed_freq_enable)
      mode_sync_pin = 1'b0;
      repeat (5) @(negedge clk);
      `CHK("bit pwm", 1'b0, forced_fixed_freq_enable)
      $display("test mode done");
      host.wr(8'h01, 8'h80);
      host.wr(8'h03, 8'h03);
      wait_ready();
      foreach (ra[i]) begin host.rd(ra[i], d); `CHK("soft", rv[i], d) end
      o1 = {spread_spectrum_enable, software_switch_enable, forced_fixed_freq_enable, output_discharge_enable,
            hiccup_mode_enable, voltage_ramp_speed};
      o23 = {setpoint_range_select, soft_start_duration, single_operation, power_good_blank_on_scaling};
      `CHK("soft ctl1", 7'h2a, o1)
      `CHK("soft ctl23", 6'h24, o23)
      $display("test soft reset done");
      end_of_test();
   end
   // watchdog: the run needs under 50 us
   initial begin
      #200us;
      fail_count++;
      end_of_test();
   end
endmodule : converter_control_registers_tb
`default_nettype wire
